/* rtl/pnpi_defines.svh */
// Offsets, reset values and field positions for the near and inhibit block
`ifndef PNPI_DEFINES_SVH
`define PNPI_DEFINES_SVH
`define PNPI_OFF_CTRL 8'h00
`define PNPI_OFF_NEAR_W 8'h04
`define PNPI_OFF_DONE_W 8'h08
`define PNPI_OFF_CMD_CNT 8'h0c
`define PNPI_OFF_FB_CNT 8'h10
`define PNPI_OFF_DEV 8'h14
`define PNPI_OFF_STATUS 8'h18
`define PNPI_OFF_IRQ_ST 8'h1c
`define PNPI_OFF_IRQ_MASK 8'h20
`define PNPI_NEAR_W_RST 16'h0064
`define PNPI_DONE_W_RST 16'h000a
`define PNPI_MODE_RST 4'h0
`define PNPI_MODE_SPEED 4'h1
`define PNPI_CTRL_MODE_LSB 4
`define PNPI_ST_NEAR 0
`define PNPI_ST_DONE 1
`define PNPI_ST_INH 2
`define PNPI_ST_LOCK 3
`endif

/* rtl/pnpi_pkg.sv */
// Types shared by the near and inhibit block
package pnpi_pkg;
   typedef logic [31:0] pnpi_word_t;
   typedef logic [3:0] pnpi_mode_t;
   typedef enum logic [1:0] {PNPI_IDLE, PNPI_ACK} pnpi_bus_state_t;
endpackage

/* rtl/pnpi_sync_if.sv */
// Interface carrying synchronised pin levels between modules
`timescale 1ns/100ps
interface pnpi_sync_if;
   logic inhibit_n;
   logic cmd_pulse;
   logic cmd_dir;
   logic fb_pulse;
   logic fb_dir;
   modport src
   (
      output inhibit_n, cmd_pulse, cmd_dir, fb_pulse, fb_dir
   );
   modport dst
   (
      input inhibit_n, cmd_pulse, cmd_dir, fb_pulse, fb_dir
   );
endinterface

/* rtl/pnpi_pin_sync.sv */
// Two-stage synchronisers and edge detect for the pin inputs
`timescale 1ns/100ps
module pnpi_pin_sync
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Raw pins
   input wire logic inhibit_pin_n,
   input wire logic cmd_step_pin,
   input wire logic cmd_dir_pin,
   input wire logic fb_step_pin,
   input wire logic fb_dir_pin,
   // Synchronised results
   pnpi_sync_if.src sync
);
   // Stage one and two per pin: 0 inhibit, 1 cmd step, 2 cmd dir, 3 fb step, 4 fb dir
   logic [4:0] meta_reg;
   logic [4:0] sync_reg;
   logic [4:0] raw;
   logic cmd_last_reg;
   logic fb_last_reg;
   assign raw = {fb_dir_pin, fb_step_pin, cmd_dir_pin, cmd_step_pin, inhibit_pin_n};
   // Synchroniser chain; inhibit rests high so it resets high
   genvar i;
   generate
      for (i = 0; i < 5; i = i + 1)
      begin : g_sync
         always_ff @(posedge clock or negedge reset_n)
         begin
            if (!reset_n)
            begin
               meta_reg[i] <= (i == 0) ? 1'b1 : 1'b0;
               sync_reg[i] <= (i == 0) ? 1'b1 : 1'b0;
            end
            else
            begin
               meta_reg[i] <= raw[i];
               sync_reg[i] <= meta_reg[i];
            end
         end
      end
   endgenerate
   // Last step levels, read only from the second stage
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         cmd_last_reg <= 1'b0;
         fb_last_reg <= 1'b0;
      end
      else
      begin
         cmd_last_reg <= sync_reg[1];
         fb_last_reg <= sync_reg[3];
      end
   end
   // Rising step edges become one-cycle pulses
   assign sync.inhibit_n = sync_reg[0];
   assign sync.cmd_pulse = sync_reg[1] & ~cmd_last_reg;
   assign sync.cmd_dir = sync_reg[2];
   assign sync.fb_pulse = sync_reg[3] & ~fb_last_reg;
   assign sync.fb_dir = sync_reg[4];
endmodule

/* rtl/pnpi_window_cmp.sv */
// Absolute deviation and window comparison
`timescale 1ns/100ps
module pnpi_window_cmp
(
   // Deviation in command units
   input wire logic [31:0] deviation,
   // Window widths
   input wire logic [15:0] near_width,
   input wire logic [15:0] done_width,
   // Results
   output logic [31:0] abs_dev,
   output logic in_near,
   output logic in_done
);
   // Magnitude; most negative value saturates rather than wrapping
   always_comb
   begin
      if (deviation == 32'h80000000)
         abs_dev = 32'h7fffffff;
      else if (deviation[31])
         abs_dev = 32'(-deviation);
      else
         abs_dev = deviation;
   end
   // Strictly below the width, so width zero never asserts
   assign in_near = abs_dev < {16'h0000, near_width};
   assign in_done = abs_dev < {16'h0000, done_width};
endmodule

/* rtl/pnpi_top.sv */
// Near-positioning window and command pulse inhibit with Wishbone registers
`timescale 1ns/100ps
`include "pnpi_defines.svh"
// Notes on behaviour
// - Near flag when deviation below near width
// - Near warns earlier than done flag
// - Deviation measured in command units
// - Inhibit stops command pulse counting
// - Inhibit holds motor in servo lock
// - Inhibit input active low
// - Inhibit works only in position mode
// - Mode digit one selects analog speed
// - Done flag, position mode, width ten
module pnpi_top
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic wb_err_o,
   // Pins
   input wire logic inhibit_n,
   input wire logic cmd_step,
   input wire logic cmd_dir,
   input wire logic fb_step,
   input wire logic fb_dir,
   output logic near_out_n,
   output logic done_out_n,
   output logic servo_lock,
   output logic speed_mode,
   // Interrupt
   output logic irq
);
   pnpi_sync_if sync_bus ();
   pnpi_pin_sync u_sync
   (
      .clock(clock),
      .reset_n(reset_n),
      .inhibit_pin_n(inhibit_n),
      .cmd_step_pin(cmd_step),
      .cmd_dir_pin(cmd_dir),
      .fb_step_pin(fb_step),
      .fb_dir_pin(fb_dir),
      .sync(sync_bus.src)
   );

   // Software state
   pnpi_pkg::pnpi_mode_t mode_reg; // Control mode digit
   logic [15:0] near_w_reg; // Near window width
   logic [15:0] done_w_reg; // Done window width
   logic [31:0] cmd_cnt_reg; // Commanded position, command units
   logic [31:0] fb_cnt_reg; // Measured position, command units
   logic [3:0] irq_st_reg; // Sticky events
   logic [3:0] irq_mask_reg; // Event enables
   logic near_reg; // Registered near flag
   logic done_reg; // Registered done flag
   pnpi_pkg::pnpi_bus_state_t bus_state;
   logic [31:0] deviation;
   logic [31:0] abs_dev;
   logic in_near;
   logic in_done;
   logic pos_mode;
   logic inhibit_active;
   logic bus_req;
   logic wr_hit;
   logic rd_status_clr;
   logic [3:0] events;
   logic [31:0] rd_data;
   logic addr_ok;

   // Decode helper used by both read and write paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   // Mode zero is position control
   // speed mode select
   assign pos_mode = (mode_reg != `PNPI_MODE_SPEED);
   assign speed_mode = ~pos_mode;

   // Inhibit only counts in position mode; a low pin is active
   // active low input
   assign inhibit_active = pos_mode & ~sync_bus.inhibit_n;

   // Counters are already scaled by the gear, so deviation is in command units
   // command unit deviation
   assign deviation = 32'(cmd_cnt_reg - fb_cnt_reg);

   pnpi_window_cmp u_cmp
   (
      .deviation(deviation),
      .near_width(near_w_reg),
      .done_width(done_w_reg),
      .abs_dev(abs_dev),
      .in_near(in_near),
      .in_done(in_done)
   );

   // Command counter; frozen while inhibited
   // stop pulse counting
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         cmd_cnt_reg <= 32'h00000000;
      else if (sync_bus.cmd_pulse && !inhibit_active)
      begin
         if (sync_bus.cmd_dir)
            cmd_cnt_reg <= cmd_cnt_reg - 32'h00000001;
         else
            cmd_cnt_reg <= cmd_cnt_reg + 32'h00000001;
      end
   end

   // Feedback counter keeps tracking the real shaft so lock can correct drift
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         fb_cnt_reg <= 32'h00000000;
      else if (sync_bus.fb_pulse)
      begin
         if (sync_bus.fb_dir)
            fb_cnt_reg <= fb_cnt_reg - 32'h00000001;
         else
            fb_cnt_reg <= fb_cnt_reg + 32'h00000001;
      end
   end

   // Servo lock request to the loop: hold present position
   // servo lock hold
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         servo_lock <= 1'b0;
      else
         servo_lock <= inhibit_active;
   end

   // Registered window flags; done exists only in position mode
   // near window compare
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         near_reg <= 1'b0;
         done_reg <= 1'b0;
      end
      else
      begin
         near_reg <= in_near;
         done_reg <= in_done & pos_mode;
      end
   end

   // Active-low outputs; with near width above done width near leads done
   // active low near
   assign near_out_n = ~near_reg;
   assign done_out_n = ~done_reg;

   // Events: near rise, done rise, inhibit engage, lock release
   assign events[`PNPI_ST_NEAR] = in_near & ~near_reg;
   assign events[`PNPI_ST_DONE] = in_done & pos_mode & ~done_reg;
   assign events[`PNPI_ST_INH] = inhibit_active & ~servo_lock;
   assign events[`PNPI_ST_LOCK] = ~inhibit_active & servo_lock;

   // Bus handshake: one wait state, ack for one cycle
   assign bus_req = wb_cyc_i & wb_stb_i & (bus_state == pnpi_pkg::PNPI_IDLE);
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         bus_state <= pnpi_pkg::PNPI_IDLE;
      else if (bus_req)
         bus_state <= pnpi_pkg::PNPI_ACK;
      else
         bus_state <= pnpi_pkg::PNPI_IDLE;
   end

   // Address decode
   always_comb
   begin
      addr_ok = 1'b1;
      rd_data = 32'h00000000;
      if (hit(wb_adr_i, `PNPI_OFF_CTRL))
         rd_data = {24'h000000, mode_reg, 4'h0};
      else if (hit(wb_adr_i, `PNPI_OFF_NEAR_W))
         rd_data = {16'h0000, near_w_reg};
      else if (hit(wb_adr_i, `PNPI_OFF_DONE_W))
         rd_data = {16'h0000, done_w_reg};
      else if (hit(wb_adr_i, `PNPI_OFF_CMD_CNT))
         rd_data = cmd_cnt_reg;
      else if (hit(wb_adr_i, `PNPI_OFF_FB_CNT))
         rd_data = fb_cnt_reg;
      else if (hit(wb_adr_i, `PNPI_OFF_DEV))
         rd_data = abs_dev;
      else if (hit(wb_adr_i, `PNPI_OFF_STATUS))
         rd_data = {28'h0000000, servo_lock, inhibit_active, done_reg, near_reg};
      else if (hit(wb_adr_i, `PNPI_OFF_IRQ_ST))
         rd_data = {28'h0000000, irq_st_reg};
      else if (hit(wb_adr_i, `PNPI_OFF_IRQ_MASK))
         rd_data = {28'h0000000, irq_mask_reg};
      else
         addr_ok = 1'b0;
   end
   assign wr_hit = bus_req & wb_we_i;
   assign rd_status_clr = bus_req & ~wb_we_i & hit(wb_adr_i, `PNPI_OFF_IRQ_ST);

   // Answer registers; unmapped addresses get err instead of ack
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         wb_ack_o <= bus_req & addr_ok;
         wb_err_o <= bus_req & ~addr_ok;
         if (bus_req && !wb_we_i)
            wb_dat_o <= rd_data;
      end
   end

   // Writable parameters, low byte lanes only where the field lives
   // software sets width order
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mode_reg <= `PNPI_MODE_RST;
         near_w_reg <= `PNPI_NEAR_W_RST;
         done_w_reg <= `PNPI_DONE_W_RST;
         irq_mask_reg <= 4'h0;
      end
      else if (wr_hit)
      begin
         if (hit(wb_adr_i, `PNPI_OFF_CTRL) && wb_sel_i[0])
            mode_reg <= wb_dat_i[`PNPI_CTRL_MODE_LSB +: 4];
         else if (hit(wb_adr_i, `PNPI_OFF_NEAR_W))
         begin
            if (wb_sel_i[0])
               near_w_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
               near_w_reg[15:8] <= wb_dat_i[15:8];
         end
         else if (hit(wb_adr_i, `PNPI_OFF_DONE_W))
         begin
            if (wb_sel_i[0])
               done_w_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
               done_w_reg[15:8] <= wb_dat_i[15:8];
         end
         else if (hit(wb_adr_i, `PNPI_OFF_IRQ_MASK) && wb_sel_i[0])
            irq_mask_reg <= wb_dat_i[3:0];
      end
   end

   // Sticky events cleared by read; a new event in the same cycle survives
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         irq_st_reg <= 4'h0;
      else if (rd_status_clr)
         irq_st_reg <= events;
      else
         irq_st_reg <= irq_st_reg | events;
   end
   assign irq = |(irq_st_reg & irq_mask_reg);

   // Inhibit in position mode freezes the command count
   inhibit_freeze_a:
   assert property (@(posedge clock) disable iff (!reset_n)
      inhibit_active |=> (cmd_cnt_reg == $past(cmd_cnt_reg)))
      else $error("command count moved while inhibited");
   // Pin level reaches lock in bounded time
   inhibit_lock_a:
   assert property (@(posedge clock) disable iff (!reset_n)
      (pos_mode && !inhibit_n) [*4] |-> servo_lock)
      else $error("low inhibit pin did not lock");
   // Speed mode ignores inhibit
   speed_ignore_a:
   assert property (@(posedge clock) disable iff (!reset_n)
      !pos_mode |-> !inhibit_active)
      else $error("inhibit active outside position mode");
   // Lock tracks inhibit one cycle later
   lock_follow_a:
   assert property (@(posedge clock) disable iff (!reset_n)
      $rose(inhibit_active) |=> servo_lock)
      else $error("servo lock not raised");
   // Near output follows window one cycle later
   near_window_a:
   assert property (@(posedge clock) disable iff (!reset_n)
      (abs_dev < {16'h0000, near_w_reg}) |=> !near_out_n)
      else $error("near output missed window");
   // Near output high outside window
   near_level_a:
   assert property (@(posedge clock) disable iff (!reset_n)
      !in_near |=> near_out_n)
      else $error("near output low outside window");

   // Done never shown in speed mode
   done_mode_a:
   assert property (@(posedge clock) disable iff (!reset_n)
      !pos_mode |=> done_out_n)
      else $error("done asserted in speed mode");

   // With ordered widths, done implies near
   near_before_a:
   assert property (@(posedge clock) disable iff (!reset_n)
      (near_w_reg > done_w_reg) && !done_out_n |-> !near_out_n)
      else $error("done without near");

   // Mode digit one gives speed mode
   mode_speed_a:
   assert property (@(posedge clock) disable iff (!reset_n)
      (mode_reg == `PNPI_MODE_SPEED) |-> speed_mode)
      else $error("speed mode not selected");

   // Deviation is difference of counters
   dev_units_a:
   assert property (@(posedge clock) disable iff (!reset_n)
      $stable(cmd_cnt_reg) && $stable(fb_cnt_reg) |-> $stable(abs_dev))
      else $error("deviation changed without count");
endmodule

/* bench/pnpi_ctrl_model.sv */
// Instruction controller model that sends a burst of step pulses
`timescale 1ns/100ps
module pnpi_ctrl_model
(
   // Clock
   input wire logic clock,
   // Burst request
   input wire logic start,
   input wire logic [7:0] count,
   input wire logic down,
   // Pins towards the drive
   output logic step,
   output logic dir,
   output logic busy
);
   // Pulses left and phase counter
   logic [7:0] left;
   logic [1:0] phase;
   initial
   begin
      step = 1'h0;
      dir = 1'h0;
      busy = 1'h0;
      left = 8'h00;
      phase = 2'h0;
   end
   // Step stays high and low three cycles each, so no edge is lost
   // Direction is set before the first edge and held through the burst
   always @(posedge clock)
   begin
      if (start && !busy)
      begin
         left <= count;
         dir <= down;
         busy <= (count != 8'h00);
         phase <= 2'h0;
      end
      else if (busy)
      begin
         phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
         if (phase == 2'h2)
         begin
            step <= !step;
            // A falling edge ends one pulse
            if (step)
            begin
               left <= left - 8'h01;
               busy <= (left != 8'h01);
            end
         end
      end
   end
endmodule

/* bench/tb_pnpi_top.sv */
// Self-checking bench for the near window and command inhibit block
`timescale 1ns/100ps
module tb_pnpi_top;
   // Clock, reset and bus master signals
   logic clock = 1'h0;
   logic reset_n = 1'h0;
   logic cyc = 1'h0;
   logic stb = 1'h0;
   logic we = 1'h0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   // Byte lanes on the bus and the lanes the next cycle should carry
   logic [3:0] sel = 4'hf;
   logic [3:0] wsel = 4'hf;
   logic [31:0] rdat, q;
   logic ack, err, last_err, near_n, done_n, lock, spd, irq;
   // Pins and partner controls
   logic inh_n = 1'h1;
   logic c_go = 1'h0;
   logic f_go = 1'h0;
   logic c_dn = 1'h0;
   logic f_dn = 1'h0;
   logic [7:0] c_cnt = 8'h00;
   logic [7:0] f_cnt = 8'h00;
   logic c_step, c_dir, c_busy, f_step, f_dir, f_busy;
   // Counters and the bench's own view of position
   int failures = 0;
   int compares = 0;
   int cpos = 0;
   int fpos = 0;
   int w_near = 100;
   int w_done = 10;
   int speed = 0;
   int n;
   // Random burst length and direction
   int cnt;
   logic dn;
   pnpi_top pnpi_top_inst (.clock(clock), .reset_n(reset_n), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .inhibit_n(inh_n),
      .cmd_step(c_step), .cmd_dir(c_dir), .fb_step(f_step), .fb_dir(f_dir),
      .near_out_n(near_n), .done_out_n(done_n), .servo_lock(lock), .speed_mode(spd),
      .irq(irq));
   pnpi_ctrl_model pnpi_ctrl_model_inst (.clock(clock), .start(c_go), .count(c_cnt),
      .down(c_dn), .step(c_step), .dir(c_dir), .busy(c_busy));
   // Same model stands in for the motor encoder
   pnpi_ctrl_model pnpi_ctrl_model_fb_inst (.clock(clock), .start(f_go), .count(f_cnt),
      .down(f_dn), .step(f_step), .dir(f_dir), .busy(f_busy));
   // Free-running clock, 100 ns period
   initial
   begin
      forever #50 clock = !clock;
   end
   // Verdict and end of run
   task finish_test;
      $display("Comparisons %0d, failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Single comparison point
   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // One classic Wishbone cycle, held until ack or err is sampled
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clock);
      cyc <= 1'h1;
      stb <= 1'h1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= wsel;
      k = 0;
      do
      begin
         @(posedge clock);
         k++;
      end
      while (ack !== 1'h1 && err !== 1'h1 && k < 50);
      if (k >= 50)
      begin
         failures++;
         finish_test();
      end
      q = rdat;
      last_err = err;
      cyc <= 1'h0;
      stb <= 1'h0;
      we <= 1'h0;
   endtask
   // Burst of steps on command or feedback, then let sync and compare settle
   task pulses(input logic fb, input int cnt, input logic dn);
      int k;
      @(posedge clock);
      if (fb)
      begin
         f_cnt <= cnt[7:0];
         f_dn <= dn;
         f_go <= 1'h1;
      end
      else
      begin
         c_cnt <= cnt[7:0];
         c_dn <= dn;
         c_go <= 1'h1;
      end
      @(posedge clock);
      f_go <= 1'h0;
      c_go <= 1'h0;
      k = 0;
      do
      begin
         @(posedge clock);
         k++;
      end
      while ((c_busy !== 1'h0 || f_busy !== 1'h0) && k < 3000);
      if (k >= 3000)
      begin
         failures++;
         finish_test();
      end
      repeat (6) @(posedge clock);
   endtask
   // Magnitude of the position gap the drive should report
   function automatic int gap(input int x, input int y);
      gap = (x > y) ? x - y : y - x;
   endfunction
   // Expected flags and counters from the bench's own positions
   task expect_pins;
      int a;
      a = gap(cpos, fpos);
      check(near_n, !(a < w_near), "near output");
      check(done_n, !(a < w_done && speed == 0), "done output");
      wb(1'h0, 8'h14, 32'h0);
      check(q, a, "deviation");
      wb(1'h0, 8'h0c, 32'h0);
      check(q, cpos, "command count");
   endtask
   // Watchdog against a hung design
   initial
   begin
      repeat (50000) @(posedge clock);
      failures++;
      finish_test();
   end
   // Main sequence
   initial
   begin
      void'($urandom(42027));
      repeat (16) @(posedge clock);
      reset_n <= 1'h1;
      wb(1'h0, 8'h04, 32'h0);
      check(q, 32'h64, "near width reset");
      wb(1'h0, 8'h08, 32'h0);
      check(q, 32'h0a, "done width reset");
      wb(1'h0, 8'h30, 32'h0);
      check(last_err, 1'h1, "unmapped access");
      expect_pins();
      // Low byte lane only: the high byte keeps its reset value
      wsel = 4'h1;
      wb(1'h1, 8'h04, 32'h0000ab37);
      wsel = 4'hf;
      wb(1'h0, 8'h04, 32'h0);
      check(q, 32'h37, "low lane write");
      w_done = 2 + $urandom % 6;
      w_near = w_done + 4 + $urandom % 20;
      wb(1'h1, 8'h04, w_near);
      wb(1'h1, 8'h08, w_done);
      // Deviation walks across both boundaries
      pulses(1'h0, w_done, 1'h0);
      cpos += w_done;
      expect_pins();
      // controller prepares on near before done
      check({near_n, done_n}, 2'h1, "near leads done");
      pulses(1'h1, 1, 1'h0);
      fpos += 1;
      expect_pins();
      pulses(1'h0, w_near - w_done, 1'h0);
      cpos += w_near - w_done;
      expect_pins();
      pulses(1'h0, 1, 1'h0);
      cpos += 1;
      expect_pins();
      for (n = 0; n < 4; n++)
      begin
         cnt = 1 + $urandom % 12;
         dn = 1'($urandom % 2);
         pulses(n[0], cnt, dn);
         if (n[0])
            fpos += dn ? -cnt : cnt;
         else
            cpos += dn ? -cnt : cnt;
         expect_pins();
      end
      wb(1'h0, 8'h08, 32'h0);
      check(q, w_done, "done width kept");
      expect_pins();
      // Inhibit in position mode raises a masked interrupt
      wb(1'h0, 8'h1c, 32'h0);
      wb(1'h1, 8'h20, 32'h4);
      @(posedge clock);
      inh_n <= 1'h0;
      repeat (6) @(posedge clock);
      check(lock, 1'h1, "servo lock");
      check(irq, 1'h1, "inhibit irq");
      pulses(1'h0, 5, 1'h0);
      expect_pins();
      wb(1'h0, 8'h18, 32'h0);
      check(q[3:2], 2'h3, "status lock");
      wb(1'h0, 8'h1c, 32'h0);
      check(q[2], 1'h1, "irq status");
      @(posedge clock);
      check(irq, 1'h0, "irq cleared");
      inh_n <= 1'h1;
      repeat (6) @(posedge clock);
      check(lock, 1'h0, "lock released");
      pulses(1'h0, 2, 1'h0);
      cpos += 2;
      expect_pins();
      // Speed mode ignores inhibit and drops the done flag
      wb(1'h1, 8'h00, 32'h10);
      speed = 1;
      check(spd, 1'h1, "speed mode");
      inh_n <= 1'h0;
      repeat (6) @(posedge clock);
      check(lock, 1'h0, "no lock in speed");
      pulses(1'h0, 3, 1'h0);
      cpos += 3;
      expect_pins();
      finish_test();
   end
endmodule
